// *** rtl/pfc_llc_gate_sequencer.sv ***
// gate timing, sequencing and protection for boost and half-bridge stages
// Functional notes
// R01: lockout releases only when supply rises above upper lockout level
// R02: lockout asserts and switching stops when supply falls below lower level
// R03: boost overvoltage kills boost gate at once, off one full cycle minimum; code frees it at the first period start with the flag clear
// R04: boost gate inhibited below minimum boost level, hysteresis pair
// R05: resonant stage shut down when boost feedback below disable level
// R06: boost starts first; resonant stage and soft start after enable level
// R07: boost pulse ends when boost current sense crosses overcurrent level
// R08: frequency at maximum holds both half-bridge gates off until it drops
// R09: frequency-limit blanking lasts whole switching cycles, clock aligned
// R10: after resonant fault, soft-start network discharged for fresh soft start
// R11: during soft start resonant feedback pulled to reference, maximum frequency
// R12: fast resonant overcurrent turns both half-bridge gates off immediately
// R13: slow overcurrent on eight consecutive cycles shuts down resonant stage
// R14: two non-overlapping half-bridge gates, equal on-times, dead time apart
// R15: high and low side each at fifty percent of switching period
// R16: one dead-time setting shared by boost and half-bridge switching
// R17: boost edges never coincide with half-bridge edges; code lets all gates drop together when lockout asserts
// R18: slow overcurrent counter cleared by a clean cycle and by lockout
// R19: flags synchronised before use; all gates low during lockout
// R20: frequency above ninety-five percent of maximum turns half-bridge off
`default_nettype none
module pfc_llc_gate_sequencer
    import gate_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SUPPLY_ABOVE_UPPER,
    input wire logic SUPPLY_BELOW_LOWER,
    input wire logic BOOST_FB_OVERVOLTAGE,
    input wire logic BOOST_FB_ABOVE_MIN_UPPER,
    input wire logic BOOST_FB_BELOW_MIN_LOWER,
    input wire logic BOOST_FB_ABOVE_RES_ENABLE,
    input wire logic BOOST_FB_BELOW_RES_DISABLE,
    input wire logic BOOST_CURRENT_OVER,
    input wire logic FREQ_AT_LIMIT,
    input wire logic RES_CURRENT_FAST_OVER,
    input wire logic RES_CURRENT_SLOW_OVER,
    input wire logic SOFT_START_DONE,
    input wire logic [PERIOD_W-1:0] SWITCH_PERIOD,
    input wire logic [PERIOD_W-1:0] BOOST_ON_TIME,
    input wire logic [PERIOD_W-1:0] DEAD_TIME,
    output logic BOOST_GATE_OUT,
    output logic HIGH_SIDE_GATE_OUT,
    output logic LOW_SIDE_GATE_OUT,
    output logic SUPPLY_LOW_LOCKOUT,
    output logic SOFT_START_ACTIVE,
    output logic SOFT_START_DISCHARGE,
    output logic RES_FAULT
);
    typedef struct packed {
        logic lockout;
        logic boost_min_ok;
        res_state_t res;
        logic [PERIOD_W-1:0] phase;
        logic half;
        logic blank;
        logic ov_hold;
        logic boost_on;
        logic boost_cut;
        logic [PERIOD_W-1:0] boost_cnt;
        logic hs;
        logic ls;
        logic bg;
        logic fault;
    } seq_state_t;
    seq_state_t s, next_s;

    logic [NUM_FLAGS-1:0] raw_flags;
    logic [NUM_FLAGS-1:0] flags;
    logic fast_oc;
    logic slow_oc;
    logic slow_trip;
    logic cycle_start;
    logic [PERIOD_W-1:0] half_period;
    logic [PERIOD_W-1:0] boost_stop;
    logic [PERIOD_W-1:0] quarter;
    logic [PERIOD_W-1:0] boost_start;

    // each of the nine flags lands at its named position, so a reordered list cannot shift a flag
    assign raw_flags[F_LOCK_UP] = SUPPLY_ABOVE_UPPER;
    assign raw_flags[F_LOCK_DN] = SUPPLY_BELOW_LOWER;
    assign raw_flags[F_OVERV] = BOOST_FB_OVERVOLTAGE;
    assign raw_flags[F_MINB_UP] = BOOST_FB_ABOVE_MIN_UPPER;
    assign raw_flags[F_MINB_DN] = BOOST_FB_BELOW_MIN_LOWER;
    assign raw_flags[F_RES_EN] = BOOST_FB_ABOVE_RES_ENABLE;
    assign raw_flags[F_RES_DIS] = BOOST_FB_BELOW_RES_DISABLE;
    assign raw_flags[F_BOOST_OC] = BOOST_CURRENT_OVER;
    assign raw_flags[F_FREQ_LIM] = FREQ_AT_LIMIT;

    // every comparator flag crosses through two flops
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_sync
            flag_sync u_sync (
                .clk(CLK),
                .rst_n(RST_N),
                .d(raw_flags[gi]),
                .q(flags[gi])
            ); // see R19
        end
    endgenerate

    flag_sync u_fast (
        .clk(CLK),
        .rst_n(RST_N),
        .d(RES_CURRENT_FAST_OVER),
        .q(fast_oc)
    ); // see R19

    flag_sync u_slow (
        .clk(CLK),
        .rst_n(RST_N),
        .d(RES_CURRENT_SLOW_OVER),
        .q(slow_oc)
    ); // see R19

    // slow overcurrent sampled once per clock while resonant stage runs
    slow_oc_filter u_slow_filt (
        .clk(CLK),
        .rst_n(RST_N),
        .clear(s.lockout || s.res == RES_OFF), // see R18
        .sample(1'b1),
        .over(slow_oc),
        .trip(slow_trip)
    ); // see R13

    // half period gives exact 50% symmetry; odd periods lose one count
    assign half_period = {1'b0, SWITCH_PERIOD[PERIOD_W-1:1]};
    assign quarter = {2'b00, SWITCH_PERIOD[PERIOD_W-1:2]};
    assign cycle_start = (s.phase == '0) && !s.half;
    // last boost phase; a dead time as long as the half cuts the pulse to one clock instead of wrapping
    assign boost_stop = (half_period > DEAD_TIME + 12'h001) ? half_period - DEAD_TIME - 12'h001 : '0;
    // boost turns on mid-half so its edges sit away from half-bridge edges
    assign boost_start = quarter; // see R17

    always_comb begin
        next_s = s;
        // lockout hysteresis from the two supply comparators
        if (s.lockout && flags[F_LOCK_UP]) begin
            next_s.lockout = 1'b0; // see R01
        end else if (!s.lockout && flags[F_LOCK_DN]) begin
            next_s.lockout = 1'b1; // see R02
        end
        // minimum boost hysteresis pair
        if (flags[F_MINB_UP]) begin
            next_s.boost_min_ok = 1'b1; // see R04
        end else if (flags[F_MINB_DN]) begin
            next_s.boost_min_ok = 1'b0; // see R04
        end
        // shared period counter, split into two equal halves
        if (s.phase >= half_period - 12'h001 || half_period == '0) begin
            next_s.phase = '0;
            next_s.half = !s.half;
        end else begin
            next_s.phase = s.phase + 12'h001;
        end
        // frequency blanking decided only at period start, for whole cycles
        if (cycle_start) begin
            next_s.blank = flags[F_FREQ_LIM]; // see R08 see R09 see R20
        end
        // overvoltage holds boost off until the first period start with the flag clear
        if (flags[F_OVERV]) begin
            next_s.ov_hold = 1'b1; // see R03
        end else if (cycle_start) begin
            next_s.ov_hold = 1'b0; // see R03
        end
        // resonant stage sequencing
        next_s.fault = 1'b0;
        case (s.res)
            RES_OFF: begin
                // re-enable waits until the soft-start network reads discharged again
                if (!s.lockout && flags[F_RES_EN] && !fast_oc
                    && !SOFT_START_DONE) begin // see R10
                    next_s.res = RES_SOFT; // see R06
                end
            end
            RES_SOFT, RES_RUN: begin
                if (s.res == RES_SOFT && SOFT_START_DONE) begin
                    next_s.res = RES_RUN; // see R11
                end
                if (fast_oc || slow_trip || flags[F_RES_DIS] || s.lockout) begin
                    next_s.res = RES_OFF; // see R05 see R12 see R13
                    next_s.fault = fast_oc || slow_trip; // see R10
                end
            end
            default: next_s.res = RES_OFF;
        endcase
        // boost pulse, one per period, width limited by current and dead time
        if (cycle_start) begin
            next_s.boost_cut = 1'b0;
        end
        if (flags[F_BOOST_OC]) begin
            next_s.boost_cut = 1'b1; // see R07
        end
        next_s.boost_cnt = s.boost_cnt;
        if (!s.half && s.phase == boost_start) begin
            next_s.boost_on = 1'b1;
            next_s.boost_cnt = '0;
        end else if (s.boost_on) begin
            next_s.boost_cnt = s.boost_cnt + 12'h001;
            // pulse ends dead time before the next half-bridge edge
            if (s.boost_cnt >= BOOST_ON_TIME || s.phase >= boost_stop) begin
                next_s.boost_on = 1'b0; // see R16 see R17
            end
        end
        next_s.bg = next_s.boost_on && !next_s.boost_cut && !flags[F_OVERV] && !next_s.ov_hold
            && next_s.boost_min_ok && !next_s.lockout; // see R03 see R04 see R07
        // half-bridge: each gate on its own half, off during dead time at start
        next_s.hs = 1'b0;
        next_s.ls = 1'b0;
        if (next_s.res != RES_OFF && !next_s.blank && !fast_oc && !next_s.lockout
            && next_s.phase >= DEAD_TIME) begin
            next_s.hs = !next_s.half; // see R14 see R15 see R16
            next_s.ls = next_s.half; // see R14 see R15
        end
        // a boost edge landing on a bridge edge waits one clock; costs one cycle of boost timing
        if ((next_s.hs != s.hs || next_s.ls != s.ls) && !next_s.lockout) begin
            next_s.bg = s.bg; // see R17
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
            s.lockout <= 1'b1;
            s.res <= RES_OFF;
        end else begin
            s <= next_s;
        end
    end

    // gates forced low under lockout from the register itself
    assign BOOST_GATE_OUT = s.bg && !s.lockout; // see R19
    assign HIGH_SIDE_GATE_OUT = s.hs && !s.lockout; // see R19
    assign LOW_SIDE_GATE_OUT = s.ls && !s.lockout; // see R19
    assign SUPPLY_LOW_LOCKOUT = s.lockout;
    assign SOFT_START_ACTIVE = (s.res == RES_SOFT); // see R11
    assign SOFT_START_DISCHARGE = (s.res == RES_OFF); // see R10
    assign RES_FAULT = s.fault;
endmodule // pfc_llc_gate_sequencer
`default_nettype wire

// *** rtl/gate_seq_pkg.sv ***
// shared constants and types for the gate sequencer
`default_nettype none
package gate_seq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int PERIOD_W = 12;                  // width of period and dead-time settings
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 12'h3E8;  // 100 kHz at 100 MHz
    localparam logic [PERIOD_W-1:0] DEAD_RST = 12'h014;
    localparam int SLOW_OC_COUNT = 8;              // consecutive cycles before slow trip
    localparam logic [3:0] SLOW_OC_LAST = 4'h8;
    localparam int SYNC_STAGES = 2;
    localparam int NUM_FLAGS = 9;
    // flag positions in the synchronised flag vector
    localparam int F_LOCK_UP = 0;
    localparam int F_LOCK_DN = 1;
    localparam int F_OVERV = 2;
    localparam int F_MINB_UP = 3;
    localparam int F_MINB_DN = 4;
    localparam int F_RES_EN = 5;
    localparam int F_RES_DIS = 6;
    localparam int F_BOOST_OC = 7;
    localparam int F_FREQ_LIM = 8;
    typedef enum logic [1:0] {RES_OFF, RES_SOFT, RES_RUN} res_state_t;
endpackage : gate_seq_pkg
`default_nettype wire

// *** rtl/flag_sync.sv ***
// two-flop synchroniser for one comparator flag
`default_nettype none
module flag_sync
    import gate_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic meta;
        logic held;
    } sync_state_t;
    sync_state_t s, next_s;

    // first stage feeds only the second
    always_comb begin
        next_s.meta = d;
        next_s.held = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.held;
endmodule // flag_sync
`default_nettype wire

// *** rtl/slow_oc_filter.sv ***
// consecutive-cycle filter for the slow resonant overcurrent
`default_nettype none
module slow_oc_filter
    import gate_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic sample,
    input wire logic over,
    output logic trip
);
    typedef struct packed {
        logic [3:0] count;
        logic trip;
    } filt_state_t;
    filt_state_t s, next_s;

    // count samples in a row above the slow level
    always_comb begin
        next_s = s;
        next_s.trip = 1'b0;
        if (clear) begin
            next_s.count = 4'h0; // see R18
        end else if (sample) begin
            if (!over) begin
                next_s.count = 4'h0; // see R18
            end else if (s.count == SLOW_OC_LAST - 4'h1) begin
                next_s.count = 4'h0;
                next_s.trip = 1'b1; // see R13
            end else begin
                next_s.count = s.count + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign trip = s.trip;
endmodule // slow_oc_filter
`default_nettype wire

// *** sim/gate_seq_properties.sv ***
// concurrent checks on the gate sequencer ports
`default_nettype none
module gate_seq_properties (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SUPPLY_ABOVE_UPPER,
    input wire logic SUPPLY_BELOW_LOWER,
    input wire logic BOOST_FB_OVERVOLTAGE,
    input wire logic BOOST_FB_BELOW_MIN_LOWER,
    input wire logic BOOST_FB_BELOW_RES_DISABLE,
    input wire logic BOOST_CURRENT_OVER,
    input wire logic RES_CURRENT_FAST_OVER,
    input wire logic BOOST_GATE_OUT,
    input wire logic HIGH_SIDE_GATE_OUT,
    input wire logic LOW_SIDE_GATE_OUT,
    input wire logic SUPPLY_LOW_LOCKOUT,
    input wire logic RES_FAULT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // flags need three samples to clear the two-flop synchroniser and the output register
    a_lock_gates_off: assert property (SUPPLY_LOW_LOCKOUT |->
        !(BOOST_GATE_OUT | HIGH_SIDE_GATE_OUT | LOW_SIDE_GATE_OUT)) else $error("gate on in lockout");
    a_lock_release: assert property ($fell(SUPPLY_LOW_LOCKOUT) |-> $past(SUPPLY_ABOVE_UPPER, 2)
        || $past(SUPPLY_ABOVE_UPPER, 3) || $past(SUPPLY_ABOVE_UPPER, 4)) else $error("lockout freed early");
    a_lock_set: assert property (SUPPLY_BELOW_LOWER [*5] |=> SUPPLY_LOW_LOCKOUT)
        else $error("lockout not set");
    a_ov_boost_off: assert property (BOOST_FB_OVERVOLTAGE [*4] |=> !BOOST_GATE_OUT)
        else $error("boost on at overvoltage");
    a_min_boost_off: assert property (BOOST_FB_BELOW_MIN_LOWER [*4] |=> !BOOST_GATE_OUT)
        else $error("boost on below minimum");
    a_ocp_boost_off: assert property (BOOST_CURRENT_OVER [*4] |=> !BOOST_GATE_OUT)
        else $error("boost on at overcurrent");
    a_res_dis_off: assert property (BOOST_FB_BELOW_RES_DISABLE [*4] |=> !(HIGH_SIDE_GATE_OUT | LOW_SIDE_GATE_OUT))
        else $error("bridge on below disable level");
    a_fast_oc_off: assert property (RES_CURRENT_FAST_OVER [*4] |=> !(HIGH_SIDE_GATE_OUT | LOW_SIDE_GATE_OUT))
        else $error("bridge on at fast overcurrent");
    a_no_overlap: assert property (!(HIGH_SIDE_GATE_OUT && LOW_SIDE_GATE_OUT))
        else $error("both bridge gates on");
    a_edge_apart: assert property ($changed(BOOST_GATE_OUT) && !SUPPLY_LOW_LOCKOUT |->
        $stable(HIGH_SIDE_GATE_OUT) && $stable(LOW_SIDE_GATE_OUT)) else $error("boost edge on bridge edge");
    a_fault_pulse: assert property (RES_FAULT |=> !RES_FAULT)
        else $error("fault pulse too long");
endmodule // gate_seq_properties
bind pfc_llc_gate_sequencer gate_seq_properties i_props (.CLK, .RST_N, .SUPPLY_ABOVE_UPPER, .SUPPLY_BELOW_LOWER,
    .BOOST_FB_OVERVOLTAGE, .BOOST_FB_BELOW_MIN_LOWER, .BOOST_FB_BELOW_RES_DISABLE, .BOOST_CURRENT_OVER,
    .RES_CURRENT_FAST_OVER, .BOOST_GATE_OUT, .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT, .SUPPLY_LOW_LOCKOUT, .RES_FAULT);
`default_nettype wire

// *** sim/power_stage_model.sv ***
// comparator model of the analog sense front
`default_nettype none
module power_stage_model (
    input wire logic clk,
    input var int vcc,
    input var int vfb,
    input var int bcur,
    input var int rcur,
    input var int fq,
    output logic [10:0] f = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels in percent; updated after the edge so the block never sees a race
    always @(posedge clk) begin
        f[0] <= vcc > 120;
        f[1] <= vcc < 90;
        f[2] <= vfb > 110;
        f[3] <= vfb > 60;
        f[4] <= vfb < 50;
        f[5] <= vfb > 90;
        f[6] <= vfb < 64;
        f[7] <= bcur > 50;
        f[8] <= fq >= 95;
        f[9] <= rcur > 80;
        f[10] <= rcur > 40;
    end
endmodule // power_stage_model
`default_nettype wire

// *** sim/test_pfc_llc_gate_sequencer.sv ***
// self-checking bench for the gate sequencer
`default_nettype none
module test_pfc_llc_gate_sequencer;
    import gate_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, ssd = 0, bg, hs, ls, lk, ssa, dis, flt;
    logic [PERIOD_W-1:0] per = 12'h028, bon = 12'h008, dt = 12'h004;
    logic [10:0] f;
    logic [31:0] h, l, b, r = 32'hC7C6B583;
    int vcc = 0, vfb = 0, bcur = 0, rcur = 0, fq = 0, n_errors = 0, n_tests = 0, nf = 0, i;
    int q[$];
    always #5 clk = ~clk;
    // fault pulses last one cycle; count them mid-cycle, away from the edge that launches them
    always @(negedge clk) if (flt === 1'b1) nf++;
    power_stage_model i_front (.clk(clk), .vcc(vcc), .vfb(vfb), .bcur(bcur), .rcur(rcur), .fq(fq), .f(f));
    pfc_llc_gate_sequencer i_dut (.CLK(clk), .RST_N(rst_n), .SUPPLY_ABOVE_UPPER(f[0]), .SUPPLY_BELOW_LOWER(f[1]),
        .BOOST_FB_OVERVOLTAGE(f[2]), .BOOST_FB_ABOVE_MIN_UPPER(f[3]), .BOOST_FB_BELOW_MIN_LOWER(f[4]),
        .BOOST_FB_ABOVE_RES_ENABLE(f[5]), .BOOST_FB_BELOW_RES_DISABLE(f[6]), .BOOST_CURRENT_OVER(f[7]),
        .FREQ_AT_LIMIT(f[8]), .RES_CURRENT_FAST_OVER(f[9]), .RES_CURRENT_SLOW_OVER(f[10]),
        .SOFT_START_DONE(ssd), .SWITCH_PERIOD(per), .BOOST_ON_TIME(bon), .DEAD_TIME(dt), .BOOST_GATE_OUT(bg),
        .HIGH_SIDE_GATE_OUT(hs), .LOW_SIDE_GATE_OUT(ls), .SUPPLY_LOW_LOCKOUT(lk), .SOFT_START_ACTIVE(ssa),
        .SOFT_START_DISCHARGE(dis), .RES_FAULT(flt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %0h got %0h", n, e, g);
        end
    endtask
    // waits end on the falling edge so outputs have settled
    task wait_p(input int n);
        repeat (n * per) @(negedge clk);
    endtask
    // on-cycle counts over one switching period
    task meas;
        h = 0;
        l = 0;
        b = 0;
        repeat (per) begin
            @(negedge clk);
            h += hs;
            l += ls;
            b += bg;
        end
    endtask
    task done(input string s);
        $display("test %s end", s);
    endtask
    task results;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        results;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk("lockout", 1, lk);
        chk("gates", 0, {bg, hs, ls});
        chk("discharge", 1, dis);
        @(posedge clk) vcc <= 130;
        vfb <= 70;
        for (i = 0; i < 20 && lk !== 1'b0; i++) @(negedge clk);
        chk("lockout", 0, lk);
        wait_p(2);
        meas;
        chk("boost runs", 1, b != 0);
        chk("high idle", 0, h);
        done("start");
        @(posedge clk) vfb <= 100;
        wait_p(3);
        chk("soft start", 1, ssa);
        @(posedge clk) ssd <= 1;
        wait_p(2);
        chk("soft start", 0, ssa);
        // random periods and dead times; the model expects equal halves minus dead time
        for (i = 0; i < 4; i++) begin
            r = lfsr(r);
            @(posedge clk) per <= 12'h028 + {r[4:0], 1'b0};
            dt <= 12'h002 + r[7:5];
            bon <= 12'h004 + r[11:8];
            wait_p(3);
            q.push_back(per / 2 - dt);
            meas;
            chk("low on", q[0], l);
            chk("high on", q.pop_front(), h);
        end
        done("symmetry");
        @(posedge clk) fq <= 100;
        wait_p(2);
        meas;
        chk("blank", 0, h + l);
        @(posedge clk) fq <= 0;
        wait_p(3);
        meas;
        chk("unblank", per / 2 - dt, h);
        @(posedge clk) vfb <= 120;
        wait_p(1);
        meas;
        chk("ov boost", 0, b);
        @(posedge clk) vfb <= 100;
        wait_p(3);
        meas;
        chk("boost back", 1, b != 0);
        done("limits");
        @(posedge clk) rcur <= 50;
        repeat (7) @(posedge clk);
        rcur <= 0;
        wait_p(1);
        chk("faults", 0, nf);
        @(posedge clk) rcur <= 50;
        repeat (14) @(posedge clk);
        rcur <= 0;
        wait_p(1);
        chk("faults", 1, nf);
        chk("discharge", 1, dis);
        meas;
        chk("held off", 0, h + l);
        // network reads discharged once done drops; only then a fresh start
        @(posedge clk) ssd <= 0;
        wait_p(4);
        chk("fresh soft start", 1, ssa);
        @(posedge clk) ssd <= 1;
        wait_p(2);
        @(posedge clk) rcur <= 90;
        repeat (6) @(posedge clk);
        rcur <= 0;
        wait_p(1);
        chk("faults", 2, nf);
        meas;
        chk("fast off", 0, h + l);
        done("overcurrent");
        @(posedge clk) bcur <= 60;
        wait_p(1);
        meas;
        chk("boost ocp", 0, b);
        @(posedge clk) bcur <= 0;
        vfb <= 40;
        wait_p(2);
        meas;
        chk("min boost", 0, b);
        @(posedge clk) vcc <= 80;
        wait_p(1);
        chk("lockout", 1, lk);
        chk("gates", 0, {bg, hs, ls});
        done("shutdown");
        results;
    end
endmodule // test_pfc_llc_gate_sequencer
`default_nettype wire
